// file: rtl/pwrdn_ctrl.sv
// Powerdown, wake and pin isolation controller for the device core.
//
// How it works
// [RULE1] Powerdown stops oscillator, clocks, bus, peripherals.
// [RULE2] Registers and RAM retained through powerdown.
// [RULE3] Bit 0 of config permits powerdown.
// [RULE4] Every reset reloads config from stored byte.
// [RULE5] Instruction operand 2 enters powerdown.
// [RULE6] Watchdog cannot reset during powerdown.
// [RULE7] Serial transfer resumes where it stopped.
// [RULE8] Software finishes conversions before powerdown.
// [RULE9] Low programming pin 50 ns wakes clocks.
// [RULE10] Board holds reset sixteen states or longer.
// [RULE11] Wake interrupt level held 50 ns wakes.
// [RULE12] Masked wake interrupt still wakes if special.
// [RULE13] Interrupt wake sets pending, runs enabled handler.
// [RULE14] Masked wake continues; pending stays until cleared.
// [RULE15] Interrupt wake waits for programming pin threshold.
// [RULE16] Isolation mode leaves pins weakly pulled only.
// [RULE17] Reset during isolation returns to reset state.
// [RULE18] Isolation entered when select low at release.
// [RULE19] Reset with select high leaves isolation.
// [RULE20] Test-mode pin low at release enters test.
// [RULE21] Software should drive isolation select pin.
// [RULE22] Disabled powerdown instruction simply continues.
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module pwrdn_ctrl (
    // Clock, enable and reset.
    input  wire logic               CLK_SYS,
    input  wire logic               CE,
    input  wire logic               SRST,
    // Avalon-MM slave.
    input  wire logic [3:0]         AVS_ADDRESS,
    input  wire logic               AVS_READ,
    input  wire logic               AVS_WRITE,
    input  wire logic [31:0]        AVS_WRITEDATA,
    output logic      [31:0]        AVS_READDATA,
    output logic                    AVS_WAITREQUEST,
    // Core side.
    input  wire logic [7:0]         CONFIG_BYTE,
    input  wire logic               INSTR_VALID,
    input  wire logic [7:0]         INSTR_OPERAND,
    input  wire logic               INT_SERVICED,
    // Board pins.
    input  wire logic               WAKE_INT_PIN,
    input  wire logic               VPP_LOW_PIN,
    input  wire logic               VPP_BELOW_THRESH,
    input  wire logic               ISO_SELECT_N_PIN,
    input  wire logic               TEST_ENTRY_N_PIN,
    input  wire logic               TEST_PIN_IS_INPUT,
    // Clock and pin control outputs.
    output pwrdn_pkg::clk_ctrl_t    CLK_CTRL,
    output logic                    WDT_RESET_BLOCK,
    output logic                    SERIAL_HOLD,
    output logic                    PINS_ISOLATED,
    output logic                    TEST_MODE,
    output logic                    RUN_HANDLER,
    output logic                    WAKE_PENDING
);

    pwrdn_pkg::op_state_t state_q;
    logic [7:0]           config_q;
    logic                 pending_q;
    logic                 iso_latch_q;
    logic                 test_q;
    logic                 handler_q;
    logic [1:0]           wake_sync_q;
    logic [1:0]           vpp_sync_q;
    logic [1:0]           thr_sync_q;
    logic [1:0]           iso_sync_q;
    logic [1:0]           tst_sync_q;
    logic [3:0]           wake_cnt_q;
    logic [3:0]           vpp_cnt_q;
    logic                 srst_d1_q;
    logic                 rd_done_q;
    logic                 pd_cmd;
    logic                 wr_cfg;
    logic                 wr_cmd;
    logic                 wr_pend;
    logic                 wake_int_ok;
    logic                 wake_vpp_ok;
    logic                 int_wake_evt;

    // Counts a filtered input held active for the minimum width.
    function automatic logic [3:0] held_count(input logic [3:0] cnt, input logic level);
        if (!level) begin
            return 4'h0;
        end
        if (cnt < 4'(pwrdn_pkg::WAKE_MIN_CYCLES)) begin
            return cnt + 4'h1;
        end
        return cnt;
    endfunction

    // Pin inputs except TEST_PIN_IS_INPUT pass two flip-flops before any logic reads them.
    always_ff @(posedge CLK_SYS) begin
        if (CE) begin
            wake_sync_q <= {wake_sync_q[0], WAKE_INT_PIN};
            vpp_sync_q  <= {vpp_sync_q[0], VPP_LOW_PIN};
            thr_sync_q  <= {thr_sync_q[0], VPP_BELOW_THRESH};
            iso_sync_q  <= {iso_sync_q[0], ISO_SELECT_N_PIN};
            tst_sync_q  <= {tst_sync_q[0], TEST_ENTRY_N_PIN};
        end
    end

    // Bus decode; writes finish at once, reads wait one cycle so registered data stands when released.
    assign AVS_WAITREQUEST = AVS_READ && !rd_done_q;
    assign wr_cfg  = AVS_WRITE && (AVS_ADDRESS == pwrdn_pkg::ADDR_CONFIG);
    assign wr_cmd  = AVS_WRITE && (AVS_ADDRESS == pwrdn_pkg::ADDR_COMMAND);
    assign wr_pend = AVS_WRITE && (AVS_ADDRESS == pwrdn_pkg::ADDR_PENDING);

    // Powerdown request comes from the core or from a command write.
    assign pd_cmd = (INSTR_VALID && (INSTR_OPERAND == pwrdn_pkg::OPERAND_POWERDOWN)) ||
                    (wr_cmd && (AVS_WRITEDATA[7:0] == pwrdn_pkg::OPERAND_POWERDOWN)); // RULE5

    // Level-held wake qualifiers, both measured on synchronised pins.
    assign wake_int_ok = (wake_cnt_q >= 4'(pwrdn_pkg::WAKE_MIN_CYCLES)) &&
                         config_q[pwrdn_pkg::PIN_SPECIAL_BIT]; // RULE12
    assign wake_vpp_ok = (vpp_cnt_q >= 4'(pwrdn_pkg::WAKE_MIN_CYCLES));
    assign int_wake_evt = (state_q == pwrdn_pkg::ST_POWERDOWN) && wake_int_ok;

    // Pulse-width counters on the wake pins, level sensitive in powerdown.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            wake_cnt_q <= 4'h0;
            vpp_cnt_q  <= 4'h0;
        end else if (CE) begin
            wake_cnt_q <= held_count(wake_cnt_q, wake_sync_q[1]); // RULE11
            vpp_cnt_q  <= held_count(vpp_cnt_q, vpp_sync_q[1]); // RULE9
        end
    end

    // Configuration register reloaded from the stored byte on every reset.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            config_q <= pwrdn_pkg::CONFIG_RESET;
        end else if (CE) begin
            if (srst_d1_q) begin
                config_q <= CONFIG_BYTE; // RULE4
            end else if (wr_cfg) begin
                config_q <= AVS_WRITEDATA[7:0];
            end
        end
    end

    // Marks the cycle after a read was registered, which ends its wait state.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rd_done_q <= 1'b0;
        end else if (CE) begin
            rd_done_q <= AVS_READ && !rd_done_q;
        end
    end

    // Reset release tracker used to catch the straps after reset.
    always_ff @(posedge CLK_SYS) begin
        if (CE) begin
            srst_d1_q <= SRST;
        end
    end

    // Straps captured at the first edge after reset release.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            iso_latch_q <= 1'b0; // RULE17
            test_q      <= 1'b0;
        end else if (CE && srst_d1_q) begin
            iso_latch_q <= !iso_sync_q[1]; // RULE18 RULE19
            test_q      <= TEST_PIN_IS_INPUT && !tst_sync_q[1]; // RULE20
        end
    end

    // Operating state machine; in powerdown, config_q changes only through bus writes, and pending_q through the wake set or a service or bus clear.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_q <= pwrdn_pkg::ST_RUN;
        end else if (CE) begin
            unique case (state_q)
                pwrdn_pkg::ST_RUN: begin
                    if (srst_d1_q && !iso_sync_q[1]) begin
                        state_q <= pwrdn_pkg::ST_ISOLATE; // RULE18
                    end else if (pd_cmd && config_q[pwrdn_pkg::PD_ENABLE_BIT]) begin
                        state_q <= pwrdn_pkg::ST_POWERDOWN; // RULE3
                    end
                end
                pwrdn_pkg::ST_POWERDOWN: begin
                    if (wake_vpp_ok) begin
                        state_q <= pwrdn_pkg::ST_RUN; // RULE9
                    end else if (wake_int_ok) begin
                        state_q <= pwrdn_pkg::ST_OSC_WAIT; // RULE11
                    end
                end
                pwrdn_pkg::ST_OSC_WAIT: begin
                    if (thr_sync_q[1]) begin
                        state_q <= pwrdn_pkg::ST_RUN; // RULE15
                    end
                end
                pwrdn_pkg::ST_ISOLATE: begin
                    state_q <= pwrdn_pkg::ST_ISOLATE; // RULE16
                end
            endcase
        end
    end

    // Pending bit: hardware set wins over a software or service clear.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pending_q <= 1'b0;
        end else if (CE) begin
            if (int_wake_evt) begin
                pending_q <= 1'b1; // RULE13
            end else if (INT_SERVICED || (wr_pend && AVS_WRITEDATA[0])) begin
                pending_q <= 1'b0; // RULE14
            end
        end
    end

    // Handler request raised at resume when the interrupt is unmasked.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            handler_q <= 1'b0;
        end else if (CE) begin
            if (state_q == pwrdn_pkg::ST_OSC_WAIT && thr_sync_q[1]) begin
                handler_q <= config_q[pwrdn_pkg::INT_ENABLE_BIT]; // RULE13 RULE14
            end else if (INT_SERVICED) begin
                handler_q <= 1'b0;
            end
        end
    end

    // Clock and pin control decoded from state.
    always_comb begin
        CLK_CTRL.osc_run           = (state_q != pwrdn_pkg::ST_POWERDOWN); // RULE1
        CLK_CTRL.cpu_clk_en        = (state_q == pwrdn_pkg::ST_RUN); // RULE1 RULE22
        CLK_CTRL.periph_clk_en     = (state_q == pwrdn_pkg::ST_RUN) || (state_q == pwrdn_pkg::ST_ISOLATE);
        CLK_CTRL.vpp_pulldown      = (state_q == pwrdn_pkg::ST_OSC_WAIT); // RULE15
        CLK_CTRL.vpp_pullup        = (state_q == pwrdn_pkg::ST_RUN); // RULE15
        CLK_CTRL.clock_output_pin_force_high = (state_q == pwrdn_pkg::ST_POWERDOWN) ||
                                     (state_q == pwrdn_pkg::ST_OSC_WAIT); // RULE1
        CLK_CTRL.bus_inactive      = (state_q != pwrdn_pkg::ST_RUN); // RULE1
    end

    // Watchdog reset and serial engine are frozen in ST_POWERDOWN and ST_OSC_WAIT.
    assign WDT_RESET_BLOCK = (state_q == pwrdn_pkg::ST_POWERDOWN) || (state_q == pwrdn_pkg::ST_OSC_WAIT); // RULE6
    assign SERIAL_HOLD     = WDT_RESET_BLOCK; // RULE7 RULE2
    assign PINS_ISOLATED   = (state_q == pwrdn_pkg::ST_ISOLATE); // RULE16
    assign TEST_MODE       = test_q;
    assign RUN_HANDLER     = handler_q;
    assign WAKE_PENDING    = pending_q;

    // Read data register; unmapped addresses read zero.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            AVS_READDATA <= pwrdn_pkg::UNMAPPED_READ;
        end else if (CE && AVS_READ && !rd_done_q) begin
            unique case (AVS_ADDRESS)
                pwrdn_pkg::ADDR_CONFIG:  AVS_READDATA <= {24'h000000, config_q};
                pwrdn_pkg::ADDR_STATUS:  AVS_READDATA <= {26'h0, test_q, iso_latch_q, state_q};
                pwrdn_pkg::ADDR_PENDING: AVS_READDATA <= {31'h0, pending_q};
                default:                 AVS_READDATA <= pwrdn_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // Assertions.
    a_pd_disabled_stays: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE22
        (CE && state_q == pwrdn_pkg::ST_RUN && pd_cmd && !config_q[0] && !srst_d1_q) |=> state_q == pwrdn_pkg::ST_RUN)
        else $error("Powerdown entered while disabled.");
    a_pd_enabled_enters: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE5
        (CE && state_q == pwrdn_pkg::ST_RUN && pd_cmd && config_q[0] && !srst_d1_q && iso_sync_q[1])
        |=> state_q == pwrdn_pkg::ST_POWERDOWN)
        else $error("Powerdown not entered.");
    a_clocks_stopped: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE1
        state_q == pwrdn_pkg::ST_POWERDOWN |-> !CLK_CTRL.osc_run && !CLK_CTRL.cpu_clk_en && CLK_CTRL.clock_output_pin_force_high)
        else $error("Clocks running in powerdown.");
    a_wake_sets_pend: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE13
        (CE && int_wake_evt) |=> pending_q && state_q == pwrdn_pkg::ST_OSC_WAIT || $past(wake_vpp_ok))
        else $error("Pending not set on wake.");
    a_wait_pulldown: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE15
        state_q == pwrdn_pkg::ST_OSC_WAIT |-> CLK_CTRL.vpp_pulldown && !CLK_CTRL.cpu_clk_en)
        else $error("Resumed before threshold.");
    a_vpp_wake: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE9
        (CE && state_q == pwrdn_pkg::ST_POWERDOWN && wake_vpp_ok) |=> CLK_CTRL.cpu_clk_en)
        else $error("Programming pin wake failed.");
    a_wdt_blocked: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE6
        state_q == pwrdn_pkg::ST_POWERDOWN |-> WDT_RESET_BLOCK && SERIAL_HOLD)
        else $error("Watchdog not blocked.");
    a_iso_pins: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE16
        PINS_ISOLATED |-> iso_latch_q)
        else $error("Isolation without strap.");
    c_powerdown: cover property (@(posedge CLK_SYS) state_q == pwrdn_pkg::ST_POWERDOWN);
    c_int_wake: cover property (@(posedge CLK_SYS) state_q == pwrdn_pkg::ST_OSC_WAIT ##1 state_q == pwrdn_pkg::ST_RUN);
    c_isolate: cover property (@(posedge CLK_SYS) PINS_ISOLATED);
    c_vpp_wake: cover property (@(posedge CLK_SYS)
        state_q == pwrdn_pkg::ST_POWERDOWN ##1 state_q == pwrdn_pkg::ST_RUN);
    c_handler: cover property (@(posedge CLK_SYS) RUN_HANDLER);

    // Bus handshake: a read waits exactly one cycle.
    a_rd_one_wait: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (CE && AVS_READ && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
        else $error("Read wait longer than one cycle.");

    // Configuration register loading and retention.
    a_cfg_reload: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE4
        (CE && srst_d1_q) |=> config_q == $past(CONFIG_BYTE))
        else $error("Config not reloaded after reset.");

    a_cfg_write: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE3
        (CE && wr_cfg && !srst_d1_q) |=> config_q == $past(AVS_WRITEDATA[7:0]))
        else $error("Config write lost.");

    a_cfg_retained: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE2
        (state_q == pwrdn_pkg::ST_POWERDOWN && !wr_cfg) |=> $stable(config_q))
        else $error("Config changed in powerdown.");

    // Wake by the interrupt pin and the pending bit.
    a_int_wake_go: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE11
        (CE && int_wake_evt && !wake_vpp_ok) |=> state_q == pwrdn_pkg::ST_OSC_WAIT)
        else $error("Interrupt wake not taken.");

    a_pend_holds: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE14
        (CE && pending_q && !INT_SERVICED && !wr_pend) |=> pending_q)
        else $error("Pending bit lost.");

    a_pend_clear: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE14
        (CE && pending_q && INT_SERVICED && !int_wake_evt) |=> !pending_q)
        else $error("Pending bit not cleared by service.");

    a_handler_masked: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE14
        (CE && state_q == pwrdn_pkg::ST_OSC_WAIT && thr_sync_q[1] && !config_q[pwrdn_pkg::INT_ENABLE_BIT])
        |=> !RUN_HANDLER)
        else $error("Handler run while masked.");

    a_handler_enabled: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE13
        (CE && state_q == pwrdn_pkg::ST_OSC_WAIT && thr_sync_q[1] && config_q[pwrdn_pkg::INT_ENABLE_BIT])
        |=> RUN_HANDLER)
        else $error("Handler not requested.");

    a_resume_pullup: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE15
        (CE && state_q == pwrdn_pkg::ST_OSC_WAIT && thr_sync_q[1])
        |=> state_q == pwrdn_pkg::ST_RUN && CLK_CTRL.vpp_pullup && !CLK_CTRL.vpp_pulldown)
        else $error("Resume without pull-up.");

    // Clock gating outside run.
    a_bus_inactive: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE1
        state_q != pwrdn_pkg::ST_RUN |-> CLK_CTRL.bus_inactive && !CLK_CTRL.cpu_clk_en)
        else $error("Bus active outside run.");

    // Isolation and test straps.
    a_iso_holds: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE16
        state_q == pwrdn_pkg::ST_ISOLATE |=> state_q == pwrdn_pkg::ST_ISOLATE)
        else $error("Isolation left without reset.");

    a_iso_reset_exit: assert property (@(posedge CLK_SYS) // RULE17
        SRST |=> state_q == pwrdn_pkg::ST_RUN && !iso_latch_q)
        else $error("Reset did not leave isolation.");

    a_iso_strap: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE18
        (CE && srst_d1_q && !iso_sync_q[1]) |=> PINS_ISOLATED)
        else $error("Isolation strap ignored.");

    a_test_strap: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE20
        (CE && srst_d1_q) |=> TEST_MODE == $past(TEST_PIN_IS_INPUT && !tst_sync_q[1]))
        else $error("Test strap wrong.");

endmodule // pwrdn_ctrl

// file: rtl/pwrdn_pkg.sv
// Package with constants and carrier types for the powerdown and isolation controller.
package pwrdn_pkg;

    // Clock rate and pulse-width timing.
    localparam int unsigned CLK_PERIOD_NS      = 50;
    localparam int unsigned WAKE_MIN_NS        = 50;
    localparam int unsigned WAKE_MIN_CYCLES    = ((WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                                 ((WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned PIN_RESET_STATES   = 16;

    // Register map, word aligned byte addresses.
    localparam logic [3:0]  ADDR_CONFIG        = 4'h0;
    localparam logic [3:0]  ADDR_COMMAND       = 4'h4;
    localparam logic [3:0]  ADDR_STATUS        = 4'h8;
    localparam logic [3:0]  ADDR_PENDING       = 4'hc;

    // Field positions.
    localparam int unsigned PD_ENABLE_BIT      = 0;
    localparam int unsigned INT_ENABLE_BIT     = 1;
    localparam int unsigned PIN_SPECIAL_BIT    = 2;
    localparam int unsigned SERIAL_ACTIVE_BIT  = 3;
    localparam logic [7:0]  OPERAND_POWERDOWN  = 8'h02;
    localparam logic [7:0]  OPERAND_IDLE       = 8'h01;

    // Reset values.
    localparam logic [7:0]  CONFIG_RESET       = 8'h00;
    localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;

    // Operating state, one-hot.
    typedef enum logic [3:0] {
        ST_RUN       = 4'b0001,
        ST_POWERDOWN = 4'b0010,
        ST_OSC_WAIT  = 4'b0100,
        ST_ISOLATE   = 4'b1000
    } op_state_t;

    // Clock and pin control bundle.
    typedef struct packed {
        logic osc_run;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic vpp_pulldown;
        logic vpp_pullup;
        logic clock_output_pin_force_high;
        logic bus_inactive;
    } clk_ctrl_t;

endpackage

// file: testbench/board_model.sv
// Board model: wake interrupt source, programming-pin driver and RC network.
`timescale 1ns/1ps
module board_model #(
    parameter int DISCHARGE_CYCLES = 20
) (
    // Clock and controls from the device.
    input  wire logic                 clk,
    input  wire pwrdn_pkg::clk_ctrl_t clk_ctrl,
    // Requests from the bench.
    input  wire logic                 wake_req,
    input  wire logic                 vpp_low_req,
    // Board pins.
    output logic                      wake_int_pin,
    output logic                      vpp_low_pin,
    output logic                      vpp_below_thresh
);
    int rc_q = DISCHARGE_CYCLES;

    // The capacitor discharges under the weak pull-down and recharges at once whenever the pull-down is off.
    always @(posedge clk) begin
        if (clk_ctrl.vpp_pulldown) begin
            rc_q <= (rc_q > 0) ? rc_q - 1 : 0;
        end else begin
            rc_q <= DISCHARGE_CYCLES;
        end
    end

    // Wake stays low except when asked, so no accidental return to full power.
    assign wake_int_pin     = wake_req;
    assign vpp_low_pin      = vpp_low_req;
    assign vpp_below_thresh = (rc_q == 0);
endmodule // board_model

// file: testbench/tb.sv
// Self-checking testbench for the powerdown and isolation controller.
`timescale 1ns/1ps
module tb;
    logic                 clk_sys = 1'b0;
    logic                 srst = 1'b1;
    logic [3:0]           avs_address = 4'h0;
    logic                 avs_read = 1'b0;
    logic                 avs_write = 1'b0;
    logic [31:0]          avs_writedata = 32'h0;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic                 instr_valid = 1'b0;
    logic [7:0]           instr_operand = 8'h00;
    logic                 int_serviced = 1'b0;
    logic                 wake_req = 1'b0;
    logic                 vpp_low_req = 1'b0;
    logic                 iso_select_n = 1'b1;
    logic                 test_entry_n = 1'b1;
    logic                 test_pin_is_input = 1'b1;
    logic                 wake_int_pin, vpp_low_pin, vpp_below_thresh;
    logic                 wdt_reset_block, serial_hold, pins_isolated, test_mode, run_handler, wake_pending;
    pwrdn_pkg::clk_ctrl_t clk_ctrl;
    logic [31:0]          rd;
    int                   fail_count = 0;
    int                   n_tests = 0;

    // Free-running system clock.
    always #25 clk_sys = ~clk_sys;

    pwrdn_ctrl dut (.CLK_SYS(clk_sys), .CE(1'b1), .SRST(srst),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .CONFIG_BYTE(8'h05), .INSTR_VALID(instr_valid), .INSTR_OPERAND(instr_operand),
        .INT_SERVICED(int_serviced), .WAKE_INT_PIN(wake_int_pin), .VPP_LOW_PIN(vpp_low_pin),
        .VPP_BELOW_THRESH(vpp_below_thresh), .ISO_SELECT_N_PIN(iso_select_n),
        .TEST_ENTRY_N_PIN(test_entry_n), .TEST_PIN_IS_INPUT(test_pin_is_input), .CLK_CTRL(clk_ctrl),
        .WDT_RESET_BLOCK(wdt_reset_block), .SERIAL_HOLD(serial_hold), .PINS_ISOLATED(pins_isolated),
        .TEST_MODE(test_mode), .RUN_HANDLER(run_handler), .WAKE_PENDING(wake_pending));

    board_model board (.clk(clk_sys), .clk_ctrl(clk_ctrl), .wake_req(wake_req), .vpp_low_req(vpp_low_req),
        .wake_int_pin(wake_int_pin), .vpp_low_pin(vpp_low_pin), .vpp_below_thresh(vpp_below_thresh));

    // Compares one value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Avalon write, held until waitrequest is seen low, then one idle edge.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do begin @(posedge clk_sys); end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Avalon read; data is taken at the edge where waitrequest is seen low.
    task automatic rd_reg(input logic [3:0] a);
        avs_address <= a;
        avs_read <= 1'b1;
        do begin @(posedge clk_sys); end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Polls the state field until it matches or the poll budget runs out.
    task automatic wait_state(input logic [3:0] e);
        int n;
        n = 0;
        do begin rd_reg(pwrdn_pkg::ADDR_STATUS); n++; end while (rd[3:0] !== e && n < 60);
        chk(rd & 32'h0000_000f, {28'h0, e});
    endtask

    // One executed powerdown instruction from the core.
    task automatic exec_pd();
        instr_valid <= 1'b1;
        instr_operand <= pwrdn_pkg::OPERAND_POWERDOWN;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
    endtask

    // Holds reset for the given cycles, then leaves room before the first request.
    task automatic do_reset(input int ncyc);
        srst <= 1'b1;
        repeat (ncyc) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    // Brings the device to powerdown and then raises the wake interrupt for two cycles.
    task automatic int_wake();
        exec_pd();
        wait_state(4'h2);
        wake_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        wake_req <= 1'b0;
        wait_state(4'h4);
        chk(32'(clk_ctrl) & 32'h48, 32'h48);
        wait_state(4'h1);
        chk(32'(clk_ctrl) & 32'h24, 32'h24);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #(6000 * 50);
        fail_count++;
        finish_test();
    end

    // Main test sequence.
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd_reg(pwrdn_pkg::ADDR_CONFIG);
        chk(rd, 32'h05);
        wait_state(4'h1);
        chk(32'(clk_ctrl) & 32'h24, 32'h24);
        rd_reg(4'h2);
        chk(rd, pwrdn_pkg::UNMAPPED_READ);
        $display("test reset done");
        wr(pwrdn_pkg::ADDR_CONFIG, 32'h0);
        exec_pd();
        repeat (4) @(posedge clk_sys);
        wait_state(4'h1);
        $display("test disabled powerdown done");
        wr(pwrdn_pkg::ADDR_CONFIG, 32'h05);
        wr(pwrdn_pkg::ADDR_COMMAND, 32'h02);
        wait_state(4'h2);
        chk(32'(clk_ctrl) & 32'h73, 32'h03);
        chk({30'h0, wdt_reset_block, serial_hold}, 32'h3);
        rd_reg(pwrdn_pkg::ADDR_CONFIG);
        chk(rd, 32'h05);
        vpp_low_req <= 1'b1;
        @(posedge clk_sys);
        vpp_low_req <= 1'b0;
        wait_state(4'h1);
        $display("test programming pin wake done");
        int_wake();
        chk({30'h0, run_handler, wake_pending}, 32'h1);
        rd_reg(pwrdn_pkg::ADDR_PENDING);
        chk(rd & 32'h1, 32'h1);
        wr(pwrdn_pkg::ADDR_PENDING, 32'h1);
        rd_reg(pwrdn_pkg::ADDR_PENDING);
        chk(rd & 32'h1, 32'h0);
        $display("test masked wake done");
        wr(pwrdn_pkg::ADDR_CONFIG, 32'h07);
        int_wake();
        chk({30'h0, run_handler, wake_pending}, 32'h3);
        int_serviced <= 1'b1;
        @(posedge clk_sys);
        int_serviced <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({30'h0, run_handler, wake_pending}, 32'h0);
        $display("test enabled wake done");
        exec_pd();
        wait_state(4'h2);
        do_reset(16);
        wait_state(4'h1);
        iso_select_n <= 1'b0;
        do_reset(4);
        chk(32'(pins_isolated), 32'h1);
        wait_state(4'h8);
        iso_select_n <= 1'b1;
        do_reset(4);
        chk(32'(pins_isolated), 32'h0);
        wait_state(4'h1);
        $display("test isolation done");
        test_entry_n <= 1'b0;
        do_reset(4);
        chk(32'(test_mode), 32'h1);
        test_pin_is_input <= 1'b0;
        do_reset(4);
        chk(32'(test_mode), 32'h0);
        test_entry_n <= 1'b1;
        $display("test mode straps done");
        finish_test();
    end
endmodule // tb
